// ===== core/tcsa_pkg.sv
package tcsa_pkg;

  // termination seen on one configuration-channel pin, as presented by the far end
  typedef enum logic [1:0] {
    TERM_OPEN = 2'h0,
    TERM_RD   = 2'h1,
    TERM_RA   = 2'h2,
    TERM_RP   = 2'h3
  } tcsa_term_t;

  // attach states, gray coded along unattached -> attached -> debug -> audio
  typedef enum logic [2:0] {
    ST_UNATTACHED = 3'h0,
    ST_ATTACHED   = 3'h1,
    ST_DBG_UNOR   = 3'h3,
    ST_DBG_OR     = 3'h2,
    ST_AUDIO      = 3'h6
  } tcsa_state_t;

  // pin-side outputs that must change together
  typedef struct packed {
    logic orient_oe;
    logic bus_power_oe;
    logic vconn_cc1;
    logic vconn_cc2;
  } tcsa_pins_t;

  localparam logic [7:0] CONN_SUMMARY_OFFSET = 8'h0E;
  localparam logic [7:0] ATTACH_STATE_OFFSET = 8'h11;

  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_SINK = 8'h2D;
  localparam logic [7:0] CODE_SINK_VCONN = 8'h2F;
  localparam logic [7:0] CODE_DEBUG = 8'h6D;
  localparam logic [7:0] CODE_AUDIO = 8'h81;

  // attach state code values; arbitrary encoding of the state machine
  localparam logic [7:0] OPST_UNATTACHED = 8'h00;
  localparam logic [7:0] OPST_ATTACHED = 8'h01;
  localparam logic [7:0] OPST_DBG_UNOR = 8'h02;
  localparam logic [7:0] OPST_DBG_OR = 8'h03;
  localparam logic [7:0] OPST_AUDIO = 8'h04;

  localparam logic [7:0] REG_RESET = 8'h00;

  // default-load time after reset: 30 ms at 50 MHz
  localparam int LOAD_TIME_US = 30000;
  localparam int CLK_MHZ = 50;
  localparam int LOAD_CYCLES = LOAD_TIME_US * CLK_MHZ;

endpackage

// ===== core/tcsa_load_timer.sv
`timescale 1ns/1ps
`default_nettype none

// counts the default-load period after reset and raises a ready level
module tcsa_load_timer #(
  parameter int CYCLES = 1500000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // status
  output logic ready
);

  logic [31:0] cnt_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0;
      ready <= 1'b0;
    end else if (!ready) begin
      if (cnt_q >= 32'(CYCLES - 1)) begin
        ready <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end

endmodule

`default_nettype wire

// ===== core/tcsa_attach_decode.sv
`timescale 1ns/1ps
`default_nettype none

module tcsa_attach_decode #(
  parameter int LOAD_CYCLES = tcsa_pkg::LOAD_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // far-end terminations on the two CC pins
  input wire logic [1:0] cc1_term,
  input wire logic [1:0] cc2_term,
  // register read port
  input wire logic [7:0] reg_addr,
  output logic [7:0] reg_rdata,
  output logic regs_ready,
  // pin controls, active-low open-drain style: oe high pulls the pin low
  output logic orient_out,
  output logic orient_oe,
  output logic bus_power_enable_out,
  output logic bus_power_enable_oe,
  output logic vconn_cc1_on,
  output logic vconn_cc2_on,
  // status
  output logic [7:0] connection_summary_code,
  output logic [7:0] attach_state_code
);

  tcsa_pkg::tcsa_term_t t1;
  tcsa_pkg::tcsa_term_t t2;
  tcsa_pkg::tcsa_state_t state_q;
  tcsa_pkg::tcsa_state_t state_d;
  tcsa_pkg::tcsa_pins_t pins_d;
  tcsa_pkg::tcsa_pins_t pins_q;
  logic [7:0] conn_d;
  logic [7:0] opst_d;
  logic load_done;

  // exact match of the pin pair; pin one is always the first argument, so a
  // swapped call reads as the flipped plug
  function automatic logic pair_is(
    input tcsa_pkg::tcsa_term_t a,
    input tcsa_pkg::tcsa_term_t b,
    input tcsa_pkg::tcsa_term_t x,
    input tcsa_pkg::tcsa_term_t y
  );
    return (a == x) && (b == y);
  endfunction

  // a sink pull-down on one pin and a cable termination on the other, either way round
  function automatic logic sink_with_cable(
    input tcsa_pkg::tcsa_term_t a,
    input tcsa_pkg::tcsa_term_t b
  );
    return pair_is(a, b, tcsa_pkg::TERM_RD, tcsa_pkg::TERM_RA) ||
      pair_is(a, b, tcsa_pkg::TERM_RA, tcsa_pkg::TERM_RD);
  endfunction

  // terminations are those the far end presents, not our own Rp
  assign t1 = tcsa_pkg::tcsa_term_t'(cc1_term);
  assign t2 = tcsa_pkg::tcsa_term_t'(cc2_term);

  // decode is purely from the current pair; debounce lives in the analog front end
  // a pair that matches no branch leaves every output at its idle value
  always_comb begin
    state_d = tcsa_pkg::ST_UNATTACHED;
    pins_d = '0;
    conn_d = tcsa_pkg::CODE_NONE;
    opst_d = tcsa_pkg::OPST_UNATTACHED;
    if (pair_is(t1, t2, tcsa_pkg::TERM_RD, tcsa_pkg::TERM_RD)) begin
      // no orientation can be told from two pull-downs
      state_d = tcsa_pkg::ST_DBG_UNOR;
      pins_d.bus_power_oe = 1'b1;
      conn_d = tcsa_pkg::CODE_DEBUG;
      opst_d = tcsa_pkg::OPST_DBG_UNOR;
    end else if (pair_is(t1, t2, tcsa_pkg::TERM_RD, tcsa_pkg::TERM_OPEN)) begin
      state_d = tcsa_pkg::ST_ATTACHED;
      pins_d.bus_power_oe = 1'b1;
      conn_d = tcsa_pkg::CODE_SINK;
      opst_d = tcsa_pkg::OPST_ATTACHED;
    end else if (pair_is(t1, t2, tcsa_pkg::TERM_OPEN, tcsa_pkg::TERM_RD)) begin
      // flipped plug: orientation pin pulled low
      state_d = tcsa_pkg::ST_ATTACHED;
      pins_d.orient_oe = 1'b1;
      pins_d.bus_power_oe = 1'b1;
      conn_d = tcsa_pkg::CODE_SINK;
      opst_d = tcsa_pkg::OPST_ATTACHED;
    end else if (pair_is(t1, t2, tcsa_pkg::TERM_RD, tcsa_pkg::TERM_RA)) begin
      // VCONN goes to the pin that shows the cable termination, except after a debug attach
      state_d = tcsa_pkg::ST_ATTACHED;
      pins_d.bus_power_oe = 1'b1;
      pins_d.vconn_cc2 = 1'b1;
      conn_d = tcsa_pkg::CODE_SINK_VCONN;
      opst_d = tcsa_pkg::OPST_ATTACHED;
    end else if (pair_is(t1, t2, tcsa_pkg::TERM_RA, tcsa_pkg::TERM_RD)) begin
      state_d = tcsa_pkg::ST_ATTACHED;
      pins_d.orient_oe = 1'b1;
      pins_d.bus_power_oe = 1'b1;
      pins_d.vconn_cc1 = 1'b1;
      conn_d = tcsa_pkg::CODE_SINK_VCONN;
      opst_d = tcsa_pkg::OPST_ATTACHED;
    end else if (pair_is(t1, t2, tcsa_pkg::TERM_RA, tcsa_pkg::TERM_RA)) begin
      // an audio adapter takes no bus power and no VCONN
      state_d = tcsa_pkg::ST_AUDIO;
      conn_d = tcsa_pkg::CODE_AUDIO;
      opst_d = tcsa_pkg::OPST_AUDIO;
    end
    // everything else (both open, Ra with open, Rp on both) stays unattached
  end

  // the oriented debug state is reached from a debug attach when one pin
  // drops to Ra while the other stays Rd; outside the debug states no history is kept
  tcsa_pkg::tcsa_state_t state_f;
  tcsa_pkg::tcsa_pins_t pins_f;
  logic [7:0] opst_f;
  logic [7:0] conn_f;

  always_comb begin
    state_f = state_d;
    pins_f = pins_d;
    opst_f = opst_d;
    conn_f = conn_d;
    unique case (state_q)
      tcsa_pkg::ST_DBG_UNOR,
      tcsa_pkg::ST_DBG_OR: begin
        // the same pair from idle would mean a powered cable; history tells them apart
        if (sink_with_cable(t1, t2)) begin
          state_f = tcsa_pkg::ST_DBG_OR;
          pins_f = '0;
          pins_f.bus_power_oe = 1'b1;
          pins_f.orient_oe = (t2 == tcsa_pkg::TERM_RD);
          opst_f = tcsa_pkg::OPST_DBG_OR;
          conn_f = tcsa_pkg::CODE_DEBUG;
        end
      end
      tcsa_pkg::ST_UNATTACHED,
      tcsa_pkg::ST_ATTACHED,
      tcsa_pkg::ST_AUDIO: begin
        // the fresh decode of the current pair stands
      end
      default: begin
        // an unused code falls back to the fresh decode, which recovers next edge
      end
    endcase
  end

  // one edge updates state, pins and both codes: no torn view is visible
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= tcsa_pkg::ST_UNATTACHED;
      pins_q <= '0;
      connection_summary_code <= tcsa_pkg::REG_RESET;
      attach_state_code <= tcsa_pkg::REG_RESET;
    end else begin
      state_q <= state_f;
      pins_q <= pins_f;
      connection_summary_code <= conn_f;
      attach_state_code <= opst_f;
    end
  end

  assign orient_oe = pins_q.orient_oe;
  assign bus_power_enable_oe = pins_q.bus_power_oe;
  assign vconn_cc1_on = pins_q.vconn_cc1;
  assign vconn_cc2_on = pins_q.vconn_cc2;
  // both pins only ever pull low or float, so the level is a constant low;
  // it still comes from a flop so every output leaves the block registered
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      orient_out <= 1'b0;
      bus_power_enable_out <= 1'b0;
    end else begin
      orient_out <= 1'b0;
      bus_power_enable_out <= 1'b0;
    end
  end

  tcsa_load_timer #(
    .CYCLES(LOAD_CYCLES)
  ) u_load (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ready(load_done)
  );

  // codes read as zero until defaults are loaded; host must wait for ready
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      regs_ready <= 1'b0;
    end else begin
      regs_ready <= load_done;
      if (!load_done) begin
        reg_rdata <= 8'h00;
      end else if (reg_addr == tcsa_pkg::CONN_SUMMARY_OFFSET) begin
        reg_rdata <= conn_f;
      end else if (reg_addr == tcsa_pkg::ATTACH_STATE_OFFSET) begin
        reg_rdata <= opst_f;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule

`default_nettype wire

// ===== verif/tcsa_far_end.sv
`timescale 1ns/1ps
`default_nettype none

// far-end model: presents a termination pair, changed just after an edge
module tcsa_far_end (
  // clock
  input wire logic core_clk,
  // requested pair, cc1 in the upper two bits
  input wire logic [3:0] want,
  // terminations seen by the port
  output logic [1:0] cc1_term,
  output logic [1:0] cc2_term
);
  always_ff @(posedge core_clk) begin
    cc1_term <= want[3:2];
    cc2_term <= want[1:0];
  end
endmodule

`default_nettype wire

// ===== verif/tcsa_attach_decode_sva.sv
`timescale 1ns/1ps
`default_nettype none

module tcsa_attach_decode_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] cc1_term,
  input wire logic [1:0] cc2_term,
  input wire logic orient_oe,
  input wire logic bus_power_enable_oe,
  input wire logic vconn_cc1_on,
  input wire logic vconn_cc2_on,
  input wire logic [7:0] connection_summary_code,
  input wire logic [7:0] attach_state_code
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_OPEN: assert property (cc1_term == 2'h0 && cc2_term == 2'h0 |=>
    connection_summary_code == 8'h00 && !bus_power_enable_oe) else $error("open pins");
  AST_SINK1: assert property (cc1_term == 2'h1 && cc2_term == 2'h0 |=>
    connection_summary_code == 8'h2D && bus_power_enable_oe && !orient_oe) else $error("sink 1");
  AST_SINK2: assert property (cc1_term == 2'h0 && cc2_term == 2'h1 |=>
    connection_summary_code == 8'h2D && orient_oe) else $error("sink 2");
  AST_CABLE: assert property (cc1_term + cc2_term == 2'h2 && cc1_term != 2'h1 |=>
    connection_summary_code == 8'h00 && !vconn_cc1_on && !vconn_cc2_on) else $error("cable");
  AST_VCONN: assert property (connection_summary_code == 8'h00 &&
    (cc1_term == 2'h1 && cc2_term == 2'h2 || cc1_term == 2'h2 && cc2_term == 2'h1) |=>
    connection_summary_code == 8'h2F &&
    vconn_cc1_on == ($past(cc1_term) == 2'h2) && vconn_cc2_on != vconn_cc1_on)
    else $error("vconn route");
  AST_RP: assert property (cc1_term == 2'h3 && cc2_term == 2'h3 |=>
    connection_summary_code == 8'h00 && !orient_oe) else $error("source pair");
  AST_DBG: assert property (cc1_term == 2'h1 && cc2_term == 2'h1 |=>
    connection_summary_code == 8'h6D && bus_power_enable_oe && !orient_oe) else $error("debug");
  AST_ODBG: assert property (connection_summary_code == 8'h6D && cc1_term == 2'h1 &&
    cc2_term == 2'h2 |=> !vconn_cc2_on && !vconn_cc1_on && !orient_oe &&
    connection_summary_code == 8'h6D && attach_state_code == 8'h03) else $error("odbg");
  AST_AUDIO: assert property (cc1_term == 2'h2 && cc2_term == 2'h2 |=>
    connection_summary_code == 8'h81 && !bus_power_enable_oe) else $error("audio");
  AST_TOGETHER: assert property (connection_summary_code == 8'h00 |->
    attach_state_code == 8'h00 && !bus_power_enable_oe) else $error("codes apart");
endmodule

bind tcsa_attach_decode tcsa_attach_decode_sva i_sva (.core_clk, .rst_n, .cc1_term,
  .cc2_term, .orient_oe, .bus_power_enable_oe, .vconn_cc1_on, .vconn_cc2_on,
  .connection_summary_code, .attach_state_code);

`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic core_clk, rst_n, regs_ready, o_oe, b_oe, v1, v2, o_out, b_out;
  logic [1:0] cc1_term, cc2_term;
  logic [3:0] want;
  logic [7:0] reg_addr, reg_rdata, summ, opst;
  int bad_count = 0, checked = 0, cyc = 0;
  wire logic [11:0] seen = {summ, o_oe, b_oe, v1, v2};

  tcsa_far_end i_far (.core_clk, .want, .cc1_term, .cc2_term);
  tcsa_attach_decode #(.LOAD_CYCLES(10)) i_dut (.core_clk, .rst_n, .cc1_term, .cc2_term,
    .reg_addr, .reg_rdata, .regs_ready, .orient_out(o_out), .orient_oe(o_oe),
    .bus_power_enable_out(b_out), .bus_power_enable_oe(b_oe), .vconn_cc1_on(v1),
    .vconn_cc2_on(v2), .connection_summary_code(summ), .attach_state_code(opst));

  always #10 core_clk = ~core_clk;

  // settled decode from idle; FFF marks pairs whose outcome no rule states
  function automatic logic [11:0] expect_of(input logic [3:0] w);
    case (w)
      4'h0, 4'h2, 4'h8, 4'hF: return 12'h000;
      4'h4: return 12'h2D4;
      4'h1: return 12'h2DC;
      4'h6: return 12'h2F5;
      4'h9: return 12'h2FE;
      4'h5: return 12'h6D4;
      4'hA: return 12'h810;
      default: return 12'hFFF;
    endcase
  endfunction

  // attach state code expected from idle for the same pairs
  function automatic logic [7:0] opst_of(input logic [3:0] w);
    case (w)
      4'h4, 4'h1, 4'h6, 4'h9: return tcsa_pkg::OPST_ATTACHED;
      4'h5: return tcsa_pkg::OPST_DBG_UNOR;
      4'hA: return tcsa_pkg::OPST_AUDIO;
      default: return tcsa_pkg::OPST_UNATTACHED;
    endcase
  endfunction

  task automatic chk(input string what, input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apply(input logic [3:0] w);
    @(posedge core_clk) want <= w;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end

  initial begin
    logic [3:0] w;
    logic [11:0] e;
    core_clk = 0;
    rst_n = 0;
    want = 4'h0;
    reg_addr = 8'h0E;
    void'($urandom(92));
    repeat (16) @(posedge core_clk);
    rst_n <= 1;
    apply(4'h4);
    chk("early read", {4'h0, reg_rdata}, 12'h000);
    for (int i = 0; i < 50 && regs_ready !== 1'b1; i++) @(posedge core_clk);
    chk("ready", {11'h0, regs_ready}, 12'h001);
    // every pair with a stated outcome once, then random ones; idle first so no history leaks in
    for (int i = 0; i < 64; i++) begin
      w = (i < 16) ? 4'(i) : 4'($urandom % 16);
      e = expect_of(w);
      if (e != 12'hFFF) begin
        apply(4'h0);
        apply(w);
        chk("pins", seen, e);
        chk("summary reg", {4'h0, reg_rdata}, {4'h0, e[11:4]});
        chk("state code", {4'h0, opst}, {4'h0, opst_of(w)});
      end
      if (i == 15) $display("test table done");
    end
    $display("test random done");
    for (int k = 0; k < 2; k++) begin
      apply(4'h0);
      apply(4'h5);
      reg_addr <= 8'h11;
      apply(k ? 4'h9 : 4'h6);
      chk("oriented debug", seen, k ? 12'h6DC : 12'h6D4);
      chk("state reg", {4'h0, reg_rdata}, 12'h003);
      reg_addr <= 8'h0E;
    end
    reg_addr <= 8'h55;
    apply(4'h0);
    chk("unmapped", {4'h0, reg_rdata}, 12'h000);
    $display("test corners done");
    // reset again in mid-run with a sink already present
    rst_n <= 0;
    reg_addr <= 8'h0E;
    want <= 4'h4;
    repeat (2) @(posedge core_clk);
    #1;
    chk("reset pins", seen, 12'h000);
    chk("reset state", {4'h0, opst}, 12'h000);
    chk("reset ready", {11'h0, regs_ready}, 12'h000);
    @(posedge core_clk) rst_n <= 1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("restart pins", seen, 12'h2D4);
    chk("restart early read", {4'h0, reg_rdata}, 12'h000);
    for (int i = 0; i < 50 && regs_ready !== 1'b1; i++) @(posedge core_clk);
    #1;
    chk("restart read", {4'h0, reg_rdata}, {4'h0, tcsa_pkg::CODE_SINK});
    chk("drive level", {10'h0, o_out, b_out}, 12'h000);
    $display("test reset done");
    report_and_stop();
  end
endmodule

`default_nettype wire
